/* core/msp_defs.svh */
`ifndef MSP_DEFS_SVH
`define MSP_DEFS_SVH
// Register byte offsets on the AXI4-Lite bus.
`define MSP_OFF_PA_DATA   8'h00
`define MSP_OFF_PA_DIR    8'h04
`define MSP_OFF_ANALOG_PIN_SELECT     8'h08
`define MSP_OFF_PB_DATA   8'h0C
`define MSP_OFF_PB_DIR    8'h10
`define MSP_OFF_CFG       8'h14
// Reset values.
`define MSP_RST_DIR       8'hFF
`define MSP_RST_ANALOG_PIN_SELECT     8'hFF
`define MSP_RST_DATA      8'h00
`define MSP_RST_CFG       8'h00
// Field positions in the configuration register.
`define MSP_CFG_OSC_LSB   0
`define MSP_CFG_OSC_MSB   2
`define MSP_CFG_PERI6     3
`define MSP_CFG_PERI7     4
// First-port pins that never drive.
`define MSP_PA_INPUT_ONLY 8'h23
// Crystal oscillator pin of the first port.
`define MSP_PA_OSC_PIN    6
`endif

/* core/msp_pin_mux.sv */
`timescale 1ns/1ps
`include "msp_defs.svh"
// Combinational pin mux for both ports: drivers, input gating and read-back.
module msp_pin_mux
  import msp_pkg::*;
(
  input  wire logic [7:0] pa_latch,     // First-port output latch.
  input  wire logic [7:0] pa_dir,       // First-port direction.
  input  wire logic [7:0] pb_latch,     // Second-port output latch.
  input  wire logic [7:0] pb_dir,       // Second-port direction.
  input  wire logic [7:0] analog_pin_select,        // Analog select.
  input  wire logic       osc_crystal,  // Crystal mode owns first-port pin 6.
  input  wire logic [1:0] peri_en,      // Peripheral owns second-port pins 7:6.
  input  wire logic [1:0] peri_out,     // Peripheral output values.
  input  wire logic [7:0] pa_in,        // First-port pin levels.
  input  wire logic [7:0] pb_in,        // Second-port pin levels.
  output msp_pins_s       pa_pins,      // First-port drive.
  output msp_pins_s       pb_pins,      // Second-port drive.
  output logic      [7:0] pa_read,      // First-port read value.
  output logic      [7:0] pb_read,      // Second-port read value.
  output logic      [7:0] pa_dig_en,    // First-port digital input buffer enables.
  output logic      [7:0] pb_dig_en     // Second-port digital input buffer enables.
);
  // Analog bits 3:0 serve the first port, bits 7:4 the second port pins 3:0.
  logic [7:0] pa_ana;
  logic [7:0] pb_ana;
  assign pa_ana = {4'h0, analog_pin_select[3:0]};
  assign pb_ana = {4'h0, analog_pin_select[7:4]};

  // Driver enables and read-back.
  always_comb begin
    pa_pins.out = pa_latch;
    // A set direction bit leaves the driver off; input-only pins never drive.
    pa_pins.oe  = ~pa_dir & ~`MSP_PA_INPUT_ONLY;
    if (osc_crystal) begin
      // The oscillator owns the pin, so direction is ignored here.
      pa_pins.oe[`MSP_PA_OSC_PIN] = 1'b0;
    end
    pb_pins.oe  = ~pb_dir;
    pb_pins.out = pb_latch;
    // Peripheral value replaces the latch; direction still gates the driver.
    if (peri_en[0]) begin
      pb_pins.out[6] = peri_out[0];
    end
    if (peri_en[1]) begin
      pb_pins.out[7] = peri_out[1];
    end
    pa_dig_en = ~pa_ana;
    pb_dig_en = ~pb_ana;
    // Analog pins read zero because their input buffer is off.
    pa_read = pa_in & pa_dig_en;
    pb_read = pb_in & pb_dig_en;
    if (osc_crystal) begin
      pa_read[`MSP_PA_OSC_PIN] = 1'b0;
    end
  end
endmodule : msp_pin_mux

/* core/msp_pkg.sv */
package msp_pkg;
  // Oscillator configurations.
  typedef enum logic [2:0] {
    MSP_OSC_LP   = 3'h0,
    MSP_OSC_XT   = 3'h1,
    MSP_OSC_HS   = 3'h2,
    MSP_OSC_EC   = 3'h3,
    MSP_OSC_RC   = 3'h4,
    MSP_OSC_INTRC = 3'h5
  } msp_osc_e;
  // One 8-bit port's pin-side signals.
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } msp_pins_s;
  // AXI4-Lite read and write answer.
  typedef enum logic [1:0] {
    MSP_RESP_OKAY   = 2'h0,
    MSP_RESP_SLVERR = 2'h2
  } msp_resp_e;
endpackage : msp_pkg

/* core/msp_port_ctrl.sv */
// Behaviour
// - First-port direction set disables output driver.
// - Analog select disables digital input buffer.
// - Only listed overrides beat direction and analog.
// - Crystal mode: pin 6 ignores direction, reads zero.
// - Second-port direction one makes input, undriven.
// - Second-port direction zero drives latch value.
// - Analog bit 4 selects second-port pin 0.
// - Analog bit 5 selects second-port pin 1.
// - Analog bit 6 selects second-port pin 2.
// - Analog bit 7 selects second-port pin 3.
// - Peripheral outputs replace latch on pins 7:6.
// - Second-port pin 0 digital, analog, interrupt, reference; only digital and analog are built here.
// - Analog pins read as zero.
// - First-port pins 0, 1, 5 input only.
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "msp_defs.svh"
// Pin-control block for two mixed-signal ports with an AXI4-Lite slave.
module msp_port_ctrl
  import msp_pkg::*;
(
  input  wire logic        aclk,          // Core clock, 10 MHz.
  input  wire logic        aresetn,       // Synchronous reset, active low.
  input  wire logic        clk_en,        // Freezes all state while low.
  input  wire logic [7:0]  s_awaddr,      // Write address.
  input  wire logic        s_awvalid,     // Write address valid.
  output logic             s_awready,     // Write address ready.
  input  wire logic [31:0] s_wdata,       // Write data.
  input  wire logic [3:0]  s_wstrb,       // Write byte strobes.
  input  wire logic        s_wvalid,      // Write data valid.
  output logic             s_wready,      // Write data ready.
  output logic [1:0]       s_bresp,       // Write response.
  output logic             s_bvalid,      // Write response valid.
  input  wire logic        s_bready,      // Write response ready.
  input  wire logic [7:0]  s_araddr,      // Read address.
  input  wire logic        s_arvalid,     // Read address valid.
  output logic             s_arready,     // Read address ready.
  output logic [31:0]      s_rdata,       // Read data.
  output logic [1:0]       s_rresp,       // Read response.
  output logic             s_rvalid,      // Read data valid.
  input  wire logic        s_rready,      // Read data ready.
  input  wire logic [1:0]  peri_en,       // Comparator or switch-mode output enables, pins 6 and 7.
  input  wire logic [1:0]  peri_out,      // Comparator or switch-mode output values, pins 6 and 7.
  input  wire logic [7:0]  pa_in,         // First-port pin levels.
  input  wire logic [7:0]  pb_in,         // Second-port pin levels.
  output logic [7:0]       pa_out,        // First-port output values.
  output logic [7:0]       pa_oe,         // First-port output enables, high drives.
  output logic [7:0]       pb_out,        // Second-port output values.
  output logic [7:0]       pb_oe,         // Second-port output enables, high drives.
  output logic [7:0]       pa_dig_en,     // First-port digital input buffer enables.
  output logic [7:0]       pb_dig_en      // Second-port digital input buffer enables.
);
  // The block keeps six byte-wide registers behind a small AXI4-Lite slave.
  // Each register sits in the low byte of its word, and the upper bytes read as zero.
  // Pin drive and buffer enables are registered, so they follow a register change
  // by one clock edge.
  // A low clock enable freezes the registers and the bus channels alike.
  // Configuration registers and their next values.
  logic [7:0]  pa_data_ff,  nxt_pa_data;
  logic [7:0]  pa_dir_ff,   nxt_pa_dir;
  logic [7:0]  analog_pin_select_ff,    nxt_analog_pin_select;
  logic [7:0]  pb_data_ff,  nxt_pb_data;
  logic [7:0]  pb_dir_ff,   nxt_pb_dir;
  logic [7:0]  cfg_ff,      nxt_cfg;
  // Each half of a write is held here until the other half arrives.
  // Bus channel state.
  logic        aw_got_ff,   nxt_aw_got;
  logic        w_got_ff,    nxt_w_got;
  logic [7:0]  awaddr_ff,   nxt_awaddr;
  logic [31:0] wdata_ff,    nxt_wdata;
  logic [3:0]  wstrb_ff,    nxt_wstrb;
  logic        bvalid_ff,   nxt_bvalid;
  logic [1:0]  bresp_ff,    nxt_bresp;
  logic        rvalid_ff,   nxt_rvalid;
  logic [31:0] rdata_ff,    nxt_rdata;
  logic [1:0]  rresp_ff,    nxt_rresp;
  // These copies feed the pins; the mux results below are never seen outside.
  // Registered pin outputs.
  msp_pins_s   pa_pins_ff,  pb_pins_ff;
  logic [7:0]  pa_den_ff,   pb_den_ff;
  // Combinational mux results.
  msp_pins_s   pa_pins_c,   pb_pins_c;
  logic [7:0]  pa_read_c,   pb_read_c;
  logic [7:0]  pa_den_c,    pb_den_c;
  logic        osc_crystal;

  // Crystal modes hand first-port pin 6 to the oscillator, so the pin mux and
  // the direction read-back both use this one flag.
  // Crystal settings are the low-power, medium and fast ones.
  assign osc_crystal = (cfg_ff[`MSP_CFG_OSC_MSB:`MSP_CFG_OSC_LSB] == MSP_OSC_LP) ||
                       (cfg_ff[`MSP_CFG_OSC_MSB:`MSP_CFG_OSC_LSB] == MSP_OSC_XT) ||
                       (cfg_ff[`MSP_CFG_OSC_MSB:`MSP_CFG_OSC_LSB] == MSP_OSC_HS);

  // Only the low strobe matters, since every register lives in byte lane 0.
  // The other strobes are accepted and ignored.
  // Merge a byte-lane write into an 8-bit register.
  function automatic logic [7:0] lane_write(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    lane_write = s[0] ? d[7:0] : old;
  endfunction : lane_write

  // An unmapped address is answered with an error and has no side effect.
  // Tell whether an address hits a mapped register.
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `MSP_OFF_PA_DATA) || (a == `MSP_OFF_PA_DIR) || (a == `MSP_OFF_ANALOG_PIN_SELECT) ||
                (a == `MSP_OFF_PB_DATA) || (a == `MSP_OFF_PB_DIR) || (a == `MSP_OFF_CFG);
  endfunction : is_mapped

  // The mux is purely combinational; its results are registered below so that
  // every pin output comes from a flip-flop.
  // Pin mux; the peripheral override is the only input that bypasses the latch.
  msp_pin_mux u_mux (
    .pa_latch    (pa_data_ff),
    .pa_dir      (pa_dir_ff),
    .pb_latch    (pb_data_ff),
    .pb_dir      (pb_dir_ff),
    .analog_pin_select       (analog_pin_select_ff),
    .osc_crystal (osc_crystal),
    .peri_en     (peri_en),
    .peri_out    (peri_out),
    .pa_in       (pa_in),
    .pb_in       (pb_in),
    .pa_pins     (pa_pins_c),
    .pb_pins     (pb_pins_c),
    .pa_read     (pa_read_c),
    .pb_read     (pb_read_c),
    .pa_dig_en   (pa_den_c),
    .pb_dig_en   (pb_den_c)
  );

  // Write channel: address and data may arrive in either order.
  always_comb begin
    // Every next value defaults to its current value, so a cycle without a
    // handshake or a commit leaves all state alone.
    nxt_aw_got  = aw_got_ff;
    nxt_w_got   = w_got_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_pa_data = pa_data_ff;
    nxt_pa_dir  = pa_dir_ff;
    nxt_analog_pin_select   = analog_pin_select_ff;
    nxt_pb_data = pb_data_ff;
    nxt_pb_dir  = pb_dir_ff;
    nxt_cfg     = cfg_ff;
    // Capture each half once, while no response is pending.
    if (s_awvalid && s_awready) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_wdata;
      nxt_wstrb = s_wstrb;
    end
    // Commit when both halves are held.
    if (aw_got_ff && w_got_ff) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = is_mapped(awaddr_ff) ? MSP_RESP_OKAY : MSP_RESP_SLVERR;
      // Only the low byte of the held data reaches the registers.
      case (awaddr_ff)
        `MSP_OFF_PA_DATA: begin
          nxt_pa_data = lane_write(pa_data_ff, wdata_ff, wstrb_ff);
        end
        `MSP_OFF_PA_DIR: begin
          nxt_pa_dir = lane_write(pa_dir_ff, wdata_ff, wstrb_ff);
        end
        `MSP_OFF_ANALOG_PIN_SELECT: begin
          nxt_analog_pin_select = lane_write(analog_pin_select_ff, wdata_ff, wstrb_ff);
        end
        `MSP_OFF_PB_DATA: begin
          nxt_pb_data = lane_write(pb_data_ff, wdata_ff, wstrb_ff);
        end
        `MSP_OFF_PB_DIR: begin
          nxt_pb_dir = lane_write(pb_dir_ff, wdata_ff, wstrb_ff);
        end
        `MSP_OFF_CFG: begin
          // Bits 4:0 are stored; bits 3 and 4 are spare and steer nothing.
          nxt_cfg = lane_write(cfg_ff, wdata_ff, wstrb_ff) & 8'h1F;
        end
        default: begin
          // Unmapped writes change nothing and answer with an error.
          nxt_cfg = cfg_ff;
        end
      endcase
    end
    // The response drops at the edge where the master accepts it.
    if (bvalid_ff && s_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // Ready while the half is not yet held and no response waits.
  // A low clock enable holds every ready low, so no address or data is lost while frozen.
  // Responses cannot be held back the same way: one accepted while frozen stays up
  // until the enable returns, so a master should leave bready and rready low then.
  assign s_awready = ~aw_got_ff & ~bvalid_ff & clk_en;
  assign s_wready  = ~w_got_ff & ~bvalid_ff & clk_en;
  assign s_arready = ~rvalid_ff & clk_en;

  // Read channel; data port reads see pins, masked for analog mode.
  always_comb begin
    // A read is answered at the same edge that takes its address, and the data
    // stands until the master takes it.
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_arvalid && s_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = is_mapped(s_araddr) ? MSP_RESP_OKAY : MSP_RESP_SLVERR;
      // Data reads see the pins through the digital enables, not the latches.
      case (s_araddr)
        `MSP_OFF_PA_DATA: nxt_rdata = {24'h0, pa_read_c};
        `MSP_OFF_PA_DIR: begin
          // The oscillator pin's direction bit reads zero in crystal mode.
          nxt_rdata = {24'h0, pa_dir_ff};
          if (osc_crystal) begin
            nxt_rdata[`MSP_PA_OSC_PIN] = 1'b0;
          end
        end
        `MSP_OFF_ANALOG_PIN_SELECT:   nxt_rdata = {24'h0, analog_pin_select_ff};
        `MSP_OFF_PB_DATA: nxt_rdata = {24'h0, pb_read_c};
        `MSP_OFF_PB_DIR:  nxt_rdata = {24'h0, pb_dir_ff};
        `MSP_OFF_CFG:     nxt_rdata = {24'h0, cfg_ff};
        default:          nxt_rdata = 32'h0000_0000;
      endcase
    end else if (rvalid_ff && s_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // Reset wins over the clock enable, so a frozen block can still be brought back
  // to its safe state; every pin leaves reset undriven since both directions load ones.
  // Registers; a low clock enable holds every flip-flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_data_ff <= `MSP_RST_DATA;
      pa_dir_ff  <= `MSP_RST_DIR;
      analog_pin_select_ff   <= `MSP_RST_ANALOG_PIN_SELECT;
      pb_data_ff <= `MSP_RST_DATA;
      pb_dir_ff  <= `MSP_RST_DIR;
      cfg_ff     <= `MSP_RST_CFG;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= 2'h0;
      pa_pins_ff <= '0;
      pb_pins_ff <= '0;
      pa_den_ff  <= 8'h00;
      pb_den_ff  <= 8'h00;
    end else if (clk_en) begin
      // Register and channel state.
      pa_data_ff <= nxt_pa_data;
      pa_dir_ff  <= nxt_pa_dir;
      analog_pin_select_ff   <= nxt_analog_pin_select;
      pb_data_ff <= nxt_pb_data;
      pb_dir_ff  <= nxt_pb_dir;
      cfg_ff     <= nxt_cfg;
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      // Pin drive is registered so the outputs come from flip-flops.
      pa_pins_ff <= pa_pins_c;
      pb_pins_ff <= pb_pins_c;
      pa_den_ff  <= pa_den_c;
      pb_den_ff  <= pb_den_c;
    end
  end

  // Plain copies of flip-flops keep the pins free of glitches when the mux
  // inputs change.
  // Output wiring straight from the flip-flops.
  assign s_bvalid  = bvalid_ff;
  assign s_bresp   = bresp_ff;
  assign s_rvalid  = rvalid_ff;
  assign s_rdata   = rdata_ff;
  assign s_rresp   = rresp_ff;
  assign pa_out    = pa_pins_ff.out;
  assign pa_oe     = pa_pins_ff.oe;
  assign pb_out    = pb_pins_ff.out;
  assign pb_oe     = pb_pins_ff.oe;
  assign pa_dig_en = pa_den_ff;
  assign pb_dig_en = pb_den_ff;
endmodule : msp_port_ctrl

/* dv/msp_props.sv */
`timescale 1ns/1ps
// Pin and bus relations of the port block, seen from its ports alone.
module msp_props
  import msp_pkg::*;
(
  input wire logic        aclk,       // Core clock.
  input wire logic        aresetn,    // Synchronous reset, active low.
  input wire logic        clk_en,     // State advances only while high.
  input wire logic        s_awvalid,  // Write address valid.
  input wire logic        s_awready,  // Write address ready.
  input wire logic        s_wvalid,   // Write data valid.
  input wire logic        s_wready,   // Write data ready.
  input wire logic        s_bvalid,   // Write response valid.
  input wire logic        s_arvalid,  // Read address valid.
  input wire logic        s_arready,  // Read address ready.
  input wire logic        s_rvalid,   // Read data valid.
  input wire logic [1:0]  peri_en,    // Peripheral output enables.
  input wire logic [1:0]  peri_out,   // Peripheral output values.
  input wire logic [7:0]  pa_oe,      // First-port output enables.
  input wire logic [7:0]  pb_oe,      // Second-port output enables.
  input wire logic [7:0]  pb_out,     // Second-port output values.
  input wire logic [7:0]  pb_dig_en   // Second-port input buffer enables.
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset must leave every pin undriven, so it is watched even while reset is low.
  reset_pins_a: assert property (disable iff (1'b0)
    !aresetn && clk_en |=> pa_oe == 8'h00 && pb_oe == 8'h00 && pb_dig_en == 8'h00) else $error("pins active after reset");
  in_only_a: assert property (
    (pa_oe & 8'h23) == 8'h00) else $error("input-only first-port pin driven");
  dig_only_a: assert property (
    $past(aresetn) && $past(clk_en) |-> pb_dig_en[7:4] == 4'hF) else $error("digital-only buffer disabled");
  peri_mux_a: assert property (
    clk_en && peri_en == 2'h3 |=> pb_out[7:6] == $past(peri_out)) else $error("peripheral value not on pins");
  // Drivers move only after a committed write, never because a peripheral was enabled.
  oe_cause_a: assert property (
    $past(aresetn) && $changed({pa_oe, pb_oe}) |-> $past(s_bvalid)) else $error("driver changed without write");
  read_lat_a: assert property (
    clk_en && s_arvalid && s_arready |=> s_rvalid) else $error("read answer late");
  write_lat_a: assert property (
    (s_awvalid && s_awready && s_wvalid && s_wready && clk_en) ##1 clk_en |=> s_bvalid) else $error("write answer late");
  wr_busy_a: assert property (
    s_bvalid |-> !s_awready && !s_wready) else $error("write taken while response pending");
  rd_busy_a: assert property (
    s_rvalid |-> !s_arready) else $error("read taken while data pending");
endmodule : msp_props

bind msp_port_ctrl msp_props i_msp_props (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_arvalid(s_arvalid),
  .s_arready(s_arready), .s_rvalid(s_rvalid), .peri_en(peri_en), .peri_out(peri_out),
  .pa_oe(pa_oe), .pb_oe(pb_oe), .pb_out(pb_out), .pb_dig_en(pb_dig_en));

/* dv/msp_tb.sv */
`timescale 1ns/1ps
`include "msp_defs.svh"
// Bench: an AXI4-Lite master programs the port block, pins are compared directly.
module testbench
  import msp_pkg::*;
;
  logic        aclk = 1'b0;      // 10 MHz core clock.
  logic        aresetn = 1'b0;   // Held low for six cycles.
  logic        clk_en = 1'b1;    // Dropped for two cycles by the second-port test.
  logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00, pa_in = 8'h00, pb_in = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0]  s_wstrb = 4'h0;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [1:0]  peri_en = 2'h0, peri_out = 2'h0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic [7:0]  pa_out, pa_oe, pb_out, pb_oe, pa_dig_en, pb_dig_en;
  int          err_total = 0;    // Mismatches seen.
  int          n_compared = 0;   // Comparisons made.

  always #50 aclk = ~aclk;

  msp_port_ctrl i_msp_port_ctrl (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .peri_en(peri_en), .peri_out(peri_out), .pa_in(pa_in), .pb_in(pb_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pb_out(pb_out), .pb_oe(pb_oe), .pa_dig_en(pa_dig_en), .pb_dig_en(pb_dig_en));

  // Compares one value; case inequality keeps unknowns from passing.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One write; address and data are offered together and each is dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
    @(posedge aclk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_wstrb   <= st;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    s_bready <= 1'b0;
    chk($sformatf("bresp_%h", a), s_bresp, er);
  endtask : wr

  // One read; data and code are taken at the edge where rvalid is seen.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    s_rready <= 1'b0;
    chk($sformatf("rdata_%h", a), s_rdata, e);
    chk($sformatf("rresp_%h", a), s_rresp, er);
  endtask : rd

  // Prints the counts and the verdict, then stops.
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Crystal mode is the reset oscillator setting, so pin 6 direction reads zero.
    rd(`MSP_OFF_PA_DIR, 32'hBF, MSP_RESP_OKAY);
    rd(`MSP_OFF_ANALOG_PIN_SELECT, 32'hFF, MSP_RESP_OKAY);
    rd(`MSP_OFF_PB_DIR, 32'hFF, MSP_RESP_OKAY);
    chk("pa_oe", pa_oe, 32'h00);
    chk("pb_oe", pb_oe, 32'h00);
    chk("pb_dig_en", pb_dig_en, 32'hF0);
    chk("pa_dig_en", pa_dig_en, 32'hF0);
    $display("test reset_values done");
    pa_in <= 8'hFF;
    pb_in <= 8'hFF;
    // Each upper analog bit silences exactly one lower second-port pin.
    for (int i = 0; i < 4; i++) begin
      wr(`MSP_OFF_ANALOG_PIN_SELECT, 32'h10 << i, 4'hF, MSP_RESP_OKAY);
      rd(`MSP_OFF_PB_DATA, 32'hFF ^ (32'h1 << i), MSP_RESP_OKAY);
      chk("pb_dig_en", pb_dig_en, 32'hFF ^ (32'h1 << i));
    end
    rd(`MSP_OFF_PA_DATA, 32'hBF, MSP_RESP_OKAY);
    $display("test analog_select done");
    wr(`MSP_OFF_PB_DATA, 32'h5A, 4'hF, MSP_RESP_OKAY);
    // Data and direction are both programmed before the pins are used.
    wr(`MSP_OFF_PB_DIR, 32'h00, 4'hF, MSP_RESP_OKAY);
    @(posedge aclk);
    chk("pb_oe", pb_oe, 32'hFF);
    chk("pb_out", pb_out, 32'h5A);
    peri_en  <= 2'h3;
    peri_out <= 2'h2;
    repeat (2) @(posedge aclk);
    chk("pb_out", pb_out, 32'h9A);
    chk("pb_oe", pb_oe, 32'hFF);
    wr(`MSP_OFF_PB_DIR, 32'hC3, 4'hF, MSP_RESP_OKAY);
    @(posedge aclk);
    chk("pb_oe", pb_oe, 32'h3C);
    // A low clock enable must hold the pins even though the override inputs move.
    clk_en   <= 1'b0;
    peri_en  <= 2'h1;
    peri_out <= 2'h0;
    repeat (2) @(posedge aclk);
    chk("pb_out_frozen", pb_out, 32'h9A);
    clk_en <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("pb_out", pb_out, 32'h1A);
    peri_en <= 2'h0;
    $display("test second_port done");
    wr(`MSP_OFF_PA_DATA, 32'hFF, 4'hF, MSP_RESP_OKAY);
    wr(`MSP_OFF_PA_DIR, 32'h00, 4'hF, MSP_RESP_OKAY);
    @(posedge aclk);
    chk("pa_oe", pa_oe, 32'h9C);
    chk("pa_out", pa_out, 32'hFF);
    // Only the three crystal settings take pin 6 away from its direction bit.
    for (int c = 0; c < 6; c++) begin
      wr(`MSP_OFF_CFG, c, 4'hF, MSP_RESP_OKAY);
      @(posedge aclk);
      chk($sformatf("pa_oe6_osc%0d", c), pa_oe[6], (c > 2) ? 32'h1 : 32'h0);
    end
    wr(`MSP_OFF_PA_DIR, 32'hF0, 4'hF, MSP_RESP_OKAY);
    @(posedge aclk);
    chk("pa_oe", pa_oe, 32'h0C);
    wr(`MSP_OFF_PA_DIR, 32'h40, 4'hF, MSP_RESP_OKAY);
    rd(`MSP_OFF_PA_DIR, 32'h40, MSP_RESP_OKAY);
    wr(`MSP_OFF_CFG, 32'h0, 4'hF, MSP_RESP_OKAY);
    rd(`MSP_OFF_PA_DIR, 32'h00, MSP_RESP_OKAY);
    $display("test first_port done");
    rd(8'h18, 32'h0, MSP_RESP_SLVERR);
    wr(8'h18, 32'hFF, 4'hF, MSP_RESP_SLVERR);
    wr(`MSP_OFF_ANALOG_PIN_SELECT, 32'hFFFF_FF00, 4'h0, MSP_RESP_OKAY);
    rd(`MSP_OFF_ANALOG_PIN_SELECT, 32'h80, MSP_RESP_OKAY);
    wr(`MSP_OFF_ANALOG_PIN_SELECT, 32'hFFFF_FF55, 4'hF, MSP_RESP_OKAY);
    rd(`MSP_OFF_ANALOG_PIN_SELECT, 32'h55, MSP_RESP_OKAY);
    rd(`MSP_OFF_PA_DATA, 32'hBA, MSP_RESP_OKAY);
    rd(`MSP_OFF_PB_DATA, 32'hFA, MSP_RESP_OKAY);
    // A second reset in mid-run must restore the safe state with every driver off.
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MSP_OFF_ANALOG_PIN_SELECT, 32'hFF, MSP_RESP_OKAY);
    chk("pb_oe", pb_oe, 32'h00);
    chk("pa_oe", pa_oe, 32'h00);
    chk("pa_dig_en", pa_dig_en, 32'hF0);
    chk("pb_dig_en", pb_dig_en, 32'hF0);
    $display("test bus_and_reset done");
    finish_test();
  end

  // The sequence needs well under a thousand cycles; ten thousand means a hang.
  initial begin
    repeat (10000) @(posedge aclk);
    err_total++;
    finish_test();
  end
endmodule : testbench
